// ### common/emod_pkg.sv
// Constants, operation codes, flag layout and request carrier for the
// extended memory operation datapath.
// Assumes a single clock domain; nothing here holds state.
package emod_pkg;

  // ----------------------------------------------------------------
  // Widths and values
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PWORD_W = 16;
  localparam int unsigned PADDR_W = 16;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  // High address byte used by the last-page table reads
  localparam logic [7:0] LAST_PAGE_HIGH = 8'hff;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] TPTR_LOW_RESET = 8'h00;
  localparam logic [7:0] TPTR_HIGH_RESET = 8'h00;
  localparam logic [7:0] TBL_HIGH_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Cycle counts, from the cycle a request is taken to done
  // ----------------------------------------------------------------
  localparam int unsigned CYC_PLAIN = 2;
  localparam int unsigned CYC_SKIP = 3;
  localparam int unsigned CYC_TABLE = 3;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    rotate_right_mem = 5'h00,
    rotate_right_to_acc = 5'h01,
    rotate_right_thru_carry = 5'h02,
    rotate_right_thru_carry_acc = 5'h03,
    subtract_with_borrow = 5'h04,
    subtract_with_borrow_to_mem = 5'h05,
    subtract_plain = 5'h06,
    subtract_plain_to_mem = 5'h07,
    decrement_skip_zero = 5'h08,
    decrement_skip_zero_acc = 5'h09,
    increment_skip_zero = 5'h0a,
    increment_skip_zero_acc = 5'h0b,
    set_byte_or_bit = 5'h0c,
    set_bit = 5'h0d,
    skip_if_nonzero = 5'h0e,
    skip_if_bit_nonzero = 5'h0f,
    skip_if_zero = 5'h10,
    skip_if_bit_zero = 5'h11,
    move_skip_if_zero = 5'h12,
    nibble_exchange = 5'h13,
    nibble_exchange_acc = 5'h14,
    table_read_page = 5'h15,
    table_read_last_page = 5'h16,
    table_read_page_preinc = 5'h17,
    table_read_last_preinc = 5'h18,
    exclusive_or_to_acc = 5'h19,
    exclusive_or_to_mem = 5'h1a
  } emod_op_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic carry;
    logic aux_carry_flag;
    logic zero;
    logic overflow_flag;
    logic signed_carry_flag;
    logic chained_zero_flag;
  } emod_flags_s;

  localparam emod_flags_s FLAGS_RESET = '0;

  typedef struct packed {
    emod_op_e op;
    logic [2:0] bit_sel;
    logic [7:0] mem_data;
  } emod_req_s;

endpackage : emod_pkg

// ### core/emod_datapath.sv
// Execution datapath for the extended data memory instruction group.
// Assumes the memory byte is presented with the request, that the program
// memory answers combinationally to the registered address, and that one
// clock and one synchronous active-low reset serve everything.
`timescale 1ns/1ps

// What this block does
// - Rotate memory right, bit 0 to 7
// - Rotated byte to accumulator, memory kept
// - Rotate through carry; only carry changes
// - Accumulator minus byte minus inverted carry
// - Subtract; carry clear if negative, else set
// - Decrement memory, skip on zero, three cycles
// - Decrement to accumulator, skip on zero
// - Increment memory, skip on zero, three cycles
// - Increment to accumulator, skip on zero
// - Set whole memory byte to all ones
// - Set one selected bit, others kept
// - Skip when selected bit is one
// - Rewrite byte, skip when byte nonzero
// - Rewrite byte, skip when byte zero
// - Copy byte to accumulator, skip on zero
// - Skip when selected bit is zero
// - Swap nibbles to memory or accumulator
// - Table read: low to memory, high latched
// - Preincrement low pointer, then table read
// - XOR to accumulator or memory, zero only
module emod_datapath (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Request
  input wire logic i_start,
  input wire emod_pkg::emod_req_s i_req,
  output logic o_busy,
  output logic o_done,
  output logic o_skip,
  // Direct loads of architectural state
  input wire logic i_acc_load,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_flags_load,
  input wire emod_pkg::emod_flags_s i_flags_wdata,
  input wire logic i_tptr_load,
  input wire logic [7:0] i_tptr_low_wdata,
  input wire logic [7:0] i_tptr_high_wdata,
  // Data memory write
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  // Program memory read
  output logic o_prog_re,
  output logic [15:0] o_prog_addr,
  input wire logic [15:0] i_prog_word,
  // Architectural state
  output logic [7:0] o_acc,
  output emod_pkg::emod_flags_s o_flags,
  output logic [7:0] o_table_pointer_low,
  output logic [7:0] o_table_pointer_high,
  output logic [7:0] o_table_read_high_latch
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_DUMMY = 4'b0100,
    ST_TABLE = 4'b1000
  } emod_state_e;

  emod_state_e state;
  emod_state_e next_state;
  emod_pkg::emod_req_s req;

  logic [7:0] m;
  logic [7:0] bit_mask;
  logic [8:0] diff;
  logic [4:0] diff_low;
  logic sub_cin;
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  logic is_sub;
  logic is_borrow;
  logic is_table;
  logic table_preinc;
  logic table_last;

  logic next_mem_we;
  logic [7:0] next_mem_data;
  logic next_acc_we;
  logic [7:0] next_acc_data;
  logic next_skip;
  emod_pkg::emod_flags_s next_flags;

  assign m = req.mem_data;
  assign bit_mask = 8'(emod_pkg::BYTE_ONE << req.bit_sel);
  assign o_busy = (state != ST_IDLE);

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  assign is_borrow = (req.op == emod_pkg::subtract_with_borrow) ||
                     (req.op == emod_pkg::subtract_with_borrow_to_mem);
  assign is_sub = is_borrow || (req.op == emod_pkg::subtract_plain) ||
                  (req.op == emod_pkg::subtract_plain_to_mem);
  // Plain subtract behaves as borrow form with carry forced to one
  assign sub_cin = is_borrow ? o_flags.carry : 1'b1;
  assign diff = {1'b0, o_acc} + {1'b0, ~m} + {8'h00, sub_cin};
  assign diff_low = {1'b0, o_acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, sub_cin};
  assign dec_val = m - emod_pkg::BYTE_ONE;
  assign inc_val = m + emod_pkg::BYTE_ONE;

  assign is_table = (req.op == emod_pkg::table_read_page) ||
                    (req.op == emod_pkg::table_read_last_page) ||
                    (req.op == emod_pkg::table_read_page_preinc) ||
                    (req.op == emod_pkg::table_read_last_preinc);
  assign table_preinc = (req.op == emod_pkg::table_read_page_preinc) ||
                        (req.op == emod_pkg::table_read_last_preinc);
  assign table_last = (req.op == emod_pkg::table_read_last_page) ||
                      (req.op == emod_pkg::table_read_last_preinc);

  // ----------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------
  always_comb begin
    next_mem_we = 1'b0;
    next_mem_data = m;
    next_acc_we = 1'b0;
    next_acc_data = o_acc;
    next_skip = 1'b0;
    next_flags = o_flags;
    case (req.op)
      emod_pkg::rotate_right_mem: begin
        next_mem_we = 1'b1;
        next_mem_data = {m[0], m[7:1]};
      end
      emod_pkg::rotate_right_to_acc: begin
        next_acc_we = 1'b1;
        next_acc_data = {m[0], m[7:1]};
      end
      emod_pkg::rotate_right_thru_carry: begin
        next_mem_we = 1'b1;
        next_mem_data = {o_flags.carry, m[7:1]};
        next_flags.carry = m[0];
      end
      emod_pkg::rotate_right_thru_carry_acc: begin
        next_acc_we = 1'b1;
        next_acc_data = {o_flags.carry, m[7:1]};
        next_flags.carry = m[0];
      end
      emod_pkg::subtract_with_borrow,
      emod_pkg::subtract_plain: begin
        next_acc_we = 1'b1;
        next_acc_data = diff[7:0];
      end
      emod_pkg::subtract_with_borrow_to_mem,
      emod_pkg::subtract_plain_to_mem: begin
        next_mem_we = 1'b1;
        next_mem_data = diff[7:0];
      end
      emod_pkg::decrement_skip_zero: begin
        next_mem_we = 1'b1;
        next_mem_data = dec_val;
        next_skip = (dec_val == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::decrement_skip_zero_acc: begin
        next_acc_we = 1'b1;
        next_acc_data = dec_val;
        next_skip = (dec_val == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::increment_skip_zero: begin
        next_mem_we = 1'b1;
        next_mem_data = inc_val;
        next_skip = (inc_val == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::increment_skip_zero_acc: begin
        next_acc_we = 1'b1;
        next_acc_data = inc_val;
        next_skip = (inc_val == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::set_byte_or_bit: begin
        next_mem_we = 1'b1;
        next_mem_data = emod_pkg::BYTE_ALL_ONES;
      end
      emod_pkg::set_bit: begin
        next_mem_we = 1'b1;
        next_mem_data = m | bit_mask;
      end
      emod_pkg::skip_if_bit_nonzero: begin
        next_skip = |(m & bit_mask);
      end
      emod_pkg::skip_if_nonzero: begin
        // Byte is rewritten unchanged
        next_mem_we = 1'b1;
        next_skip = (m != emod_pkg::BYTE_ZERO);
      end
      emod_pkg::skip_if_zero: begin
        next_mem_we = 1'b1;
        next_skip = (m == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::move_skip_if_zero: begin
        next_acc_we = 1'b1;
        next_acc_data = m;
        next_skip = (m == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::skip_if_bit_zero: begin
        next_skip = ~|(m & bit_mask);
      end
      emod_pkg::nibble_exchange: begin
        next_mem_we = 1'b1;
        next_mem_data = {m[3:0], m[7:4]};
      end
      emod_pkg::nibble_exchange_acc: begin
        next_acc_we = 1'b1;
        next_acc_data = {m[3:0], m[7:4]};
      end
      emod_pkg::exclusive_or_to_acc: begin
        next_acc_we = 1'b1;
        next_acc_data = o_acc ^ m;
        next_flags.zero = ((o_acc ^ m) == emod_pkg::BYTE_ZERO);
      end
      emod_pkg::exclusive_or_to_mem: begin
        next_mem_we = 1'b1;
        next_mem_data = o_acc ^ m;
        next_flags.zero = ((o_acc ^ m) == emod_pkg::BYTE_ZERO);
      end
      default: begin
        next_mem_we = 1'b0;
      end
    endcase
    if (is_sub) begin
      next_flags.carry = diff[8];
      next_flags.aux_carry_flag = diff_low[4];
      next_flags.zero = (diff[7:0] == emod_pkg::BYTE_ZERO);
      next_flags.overflow_flag = (o_acc[7] != m[7]) && (diff[7] != o_acc[7]);
      next_flags.signed_carry_flag = diff[7] ^
        ((o_acc[7] != m[7]) && (diff[7] != o_acc[7]));
      // Chained zero keeps history across a multi-byte borrow chain
      next_flags.chained_zero_flag = (diff[7:0] == emod_pkg::BYTE_ZERO) &&
        (!is_borrow || o_flags.chained_zero_flag);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_start) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_table) begin
          next_state = ST_TABLE;
        end else if (next_skip) begin
          next_state = ST_DUMMY;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_DUMMY: begin
        next_state = ST_IDLE;
      end
      ST_TABLE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // Request is captured once so the memory byte may change afterwards
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      req <= '0;
    end else if (i_ce && state == ST_IDLE && i_start) begin
      req <= i_req;
    end
  end

  // ----------------------------------------------------------------
  // Completion and skip strobes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_done <= 1'b0;
      o_skip <= 1'b0;
    end else if (i_ce) begin
      o_done <= (state == ST_EXEC && !is_table && !next_skip) ||
                (state == ST_DUMMY) || (state == ST_TABLE);
      o_skip <= (state == ST_EXEC && !is_table && next_skip);
    end
  end

  // ----------------------------------------------------------------
  // Data memory write port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= emod_pkg::BYTE_ZERO;
    end else if (i_ce) begin
      o_mem_we <= 1'b0;
      if (state == ST_EXEC && !is_table && next_mem_we) begin
        o_mem_we <= 1'b1;
        o_mem_wdata <= next_mem_data;
      end else if (state == ST_TABLE) begin
        o_mem_we <= 1'b1;
        o_mem_wdata <= i_prog_word[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_acc <= emod_pkg::ACC_RESET;
    end else if (i_ce) begin
      if (state == ST_EXEC && next_acc_we) begin
        o_acc <= next_acc_data;
      end else if (state == ST_IDLE && i_acc_load) begin
        o_acc <= i_acc_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_flags <= emod_pkg::FLAGS_RESET;
    end else if (i_ce) begin
      if (state == ST_EXEC) begin
        o_flags <= next_flags;
      end else if (state == ST_IDLE && i_flags_load) begin
        o_flags <= i_flags_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Table pointer, program read and high-byte latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_table_pointer_low <= emod_pkg::TPTR_LOW_RESET;
      o_table_pointer_high <= emod_pkg::TPTR_HIGH_RESET;
    end else if (i_ce) begin
      if (state == ST_EXEC && table_preinc) begin
        o_table_pointer_low <= o_table_pointer_low + emod_pkg::BYTE_ONE;
      end else if (state == ST_IDLE && i_tptr_load) begin
        o_table_pointer_low <= i_tptr_low_wdata;
        o_table_pointer_high <= i_tptr_high_wdata;
      end
    end
  end

  // Address uses the pointer after any preincrement
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_prog_re <= 1'b0;
      o_prog_addr <= 16'h0000;
    end else if (i_ce) begin
      o_prog_re <= (state == ST_EXEC && is_table);
      if (state == ST_EXEC && is_table) begin
        o_prog_addr <= {table_last ? emod_pkg::LAST_PAGE_HIGH : o_table_pointer_high,
                        table_preinc ? o_table_pointer_low + emod_pkg::BYTE_ONE
                                     : o_table_pointer_low};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_table_read_high_latch <= emod_pkg::TBL_HIGH_RESET;
    end else if (i_ce && state == ST_TABLE) begin
      o_table_read_high_latch <= i_prog_word[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || !i_ce);

  sequence exec_skip_s;
    state == ST_EXEC && !is_table && next_skip;
  endsequence

  sequence skip_tail_s;
    o_skip && state == ST_DUMMY ##1 o_done;
  endsequence

  rot_mem_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::rotate_right_mem |=>
      o_mem_we && o_mem_wdata == {$past(m[0]), $past(m[7:1])})
    else $error("rotate right result wrong");

  rot_acc_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::rotate_right_to_acc |=>
      !o_mem_we && o_acc == {$past(m[0]), $past(m[7:1])} && $stable(o_flags))
    else $error("rotate to accumulator wrong");

  rot_carry_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::rotate_right_thru_carry |=>
      o_flags.carry == $past(m[0]) && o_mem_wdata[7] == $past(o_flags.carry))
    else $error("rotate through carry wrong");

  sub_carry_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::subtract_plain |=>
      o_flags.carry == ($past(o_acc) >= $past(m)))
    else $error("subtract carry wrong");

  skip_timing_a: assert property (
    exec_skip_s |=> skip_tail_s)
    else $error("skip does not take three cycles");

  skip_total_a: assert property (
    state == ST_IDLE && i_start ##1 exec_skip_s |=> !o_done ##1 o_done)
    else $error("skip completion off");

  set_byte_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::set_byte_or_bit |=>
      o_mem_we && o_mem_wdata == emod_pkg::BYTE_ALL_ONES)
    else $error("set byte wrong");

  bit_skip_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::skip_if_bit_nonzero |=>
      o_skip == |($past(m) & $past(bit_mask)))
    else $error("bit test skip wrong");

  table_seq_a: assert property (
    state == ST_EXEC && is_table |=> o_prog_re ##1
      (o_mem_we && o_done && o_table_read_high_latch == $past(i_prog_word[15:8])))
    else $error("table read sequence wrong");

  xor_flags_a: assert property (
    state == ST_EXEC && req.op == emod_pkg::exclusive_or_to_acc |=>
      o_flags.carry == $past(o_flags.carry) &&
      o_flags.zero == (o_acc == emod_pkg::BYTE_ZERO))
    else $error("xor flags wrong");

  dummy_hold_a: assert property (
    state == ST_DUMMY |=> $stable(o_flags) && !o_mem_we)
    else $error("dummy cycle changed state");

endmodule : emod_datapath

// ### verification/emod_datapath_tb.sv
// Self-checking bench for the extended memory operation datapath.
// Assumes the design's own assertions sit in its files; the bench drives all
// inputs at the falling edge and acts as the program memory.
`timescale 1ns/1ps

module emod_datapath_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_start = 1'b0;
  logic i_ce = 1'b1;
  emod_pkg::emod_req_s i_req = '0;
  logic o_busy, o_done, o_skip, o_mem_we, o_prog_re;
  logic i_acc_load = 1'b0;
  logic [7:0] i_acc_wdata = 8'h00;
  logic i_flags_load = 1'b0;
  emod_pkg::emod_flags_s i_flags_wdata = '0;
  logic i_tptr_load = 1'b0;
  logic [7:0] i_tptr_low_wdata = 8'h00;
  logic [7:0] i_tptr_high_wdata = 8'h00;
  logic [7:0] o_mem_wdata, o_acc, o_table_pointer_low, o_table_pointer_high;
  logic [7:0] o_table_read_high_latch;
  logic [15:0] o_prog_addr;
  logic [15:0] i_prog_word = 16'hab5c;
  emod_pkg::emod_flags_s o_flags;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] seen_addr;
  localparam int CP = emod_pkg::CYC_PLAIN;
  localparam int CS = emod_pkg::CYC_SKIP;

  always #10 i_clk = ~i_clk;

  emod_datapath emod_datapath_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_start(i_start), .i_req(i_req), .o_busy(o_busy), .o_done(o_done),
    .o_skip(o_skip), .i_acc_load(i_acc_load), .i_acc_wdata(i_acc_wdata),
    .i_flags_load(i_flags_load), .i_flags_wdata(i_flags_wdata),
    .i_tptr_load(i_tptr_load), .i_tptr_low_wdata(i_tptr_low_wdata),
    .i_tptr_high_wdata(i_tptr_high_wdata), .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata), .o_prog_re(o_prog_re), .o_prog_addr(o_prog_addr),
    .i_prog_word(i_prog_word), .o_acc(o_acc), .o_flags(o_flags),
    .o_table_pointer_low(o_table_pointer_low),
    .o_table_pointer_high(o_table_pointer_high),
    .o_table_read_high_latch(o_table_read_high_latch)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // Loads only land while idle, so every caller is between operations
  task automatic setup(logic [7:0] a, logic [5:0] f, logic [7:0] tl, logic [7:0] th);
    @(negedge i_clk);
    {i_acc_load, i_flags_load, i_tptr_load} = 3'h7;
    i_acc_wdata = a;
    i_flags_wdata = emod_pkg::emod_flags_s'(f);
    {i_tptr_low_wdata, i_tptr_high_wdata} = {tl, th};
    @(negedge i_clk);
    {i_acc_load, i_flags_load, i_tptr_load} = 3'h0;
  endtask : setup

  task automatic run(emod_pkg::emod_op_e op, logic [2:0] bs, logic [7:0] m, logic we_e,
                     logic [7:0] wd_e, logic [7:0] acc_e, logic [5:0] f_e, logic sk_e,
                     int cyc);
    logic we;
    logic sk;
    logic [7:0] wd;
    int n;
    we = 1'b0;
    sk = 1'b0;
    wd = 8'h00;
    // Start cycle is cycle 0; the second wait below already lands in cycle 1
    n = 1;
    @(negedge i_clk);
    i_start = 1'b1;
    i_req = '{op, bs, m};
    @(negedge i_clk);
    i_start = 1'b0;
    chk("busy", 16'h0001, 16'(o_busy));
    // Bounded wait on completion so a stuck sequencer cannot hang the run
    while (n < 8) begin
      @(negedge i_clk);
      n++;
      if (o_mem_we === 1'b1) {we, wd} = {1'b1, o_mem_wdata};
      if (o_skip === 1'b1) sk = 1'b1;
      if (o_prog_re === 1'b1) seen_addr = o_prog_addr;
      if (o_done === 1'b1) break;
    end
    chk("mem_we", 16'(we_e), 16'(we));
    if (we_e) chk("mem_wdata", 16'(wd_e), 16'(wd));
    chk("acc", 16'(acc_e), 16'(o_acc));
    chk("flags", 16'(f_e), 16'(o_flags));
    chk("skip", 16'(sk_e), 16'(sk));
    chk("cycles", 16'(cyc), 16'(n));
    $display("test %s done", op.name());
  endtask : run

  task automatic tbl(emod_pkg::emod_op_e op, logic [15:0] a_e, logic [7:0] tl_e);
    run(op, 3'h0, 8'h00, 1'b1, 8'h5c, 8'h11, 6'h25, 1'b0, emod_pkg::CYC_TABLE);
    chk("prog_addr", a_e, seen_addr);
    chk("tptr_low", 16'(tl_e), 16'(o_table_pointer_low));
    chk("high_latch", 16'h00ab, 16'(o_table_read_high_latch));
  endtask : tbl

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    emod_pkg::emod_op_e sops[4];
    logic [7:0] sa[3];
    logic [7:0] sm[3];
    logic [5:0] sf[3];
    logic [13:0] e;
    logic [8:0] d;
    logic [4:0] h;
    logic b;
    logic ov;
    logic z;
    logic brw;
    sops = '{emod_pkg::subtract_with_borrow, emod_pkg::subtract_with_borrow_to_mem,
             emod_pkg::subtract_plain, emod_pkg::subtract_plain_to_mem};
    sa = '{8'h05, 8'h80, 8'h10};
    sm = '{8'h07, 8'h01, 8'h0f};
    sf = '{6'h21, 6'h00, 6'h01};
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    chk("reset_acc", 16'(emod_pkg::ACC_RESET), 16'(o_acc));
    chk("reset_flags", 16'h0000, 16'(o_flags));
    setup(8'h77, 6'h25, 8'hfe, 8'h22);
    run(emod_pkg::rotate_right_mem, 3'h0, 8'h81, 1, 8'hc0, 8'h77, 6'h25, 0, CP);
    run(emod_pkg::rotate_right_to_acc, 3'h0, 8'h01, 0, 8'h00, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::rotate_right_thru_carry, 3'h0, 8'h02, 1, 8'h81, 8'h80, 6'h05, 0, CP);
    run(emod_pkg::rotate_right_thru_carry_acc, 3'h0, 8'h03, 0, 8'h00, 8'h01, 6'h25, 0, CP);
    run(emod_pkg::decrement_skip_zero, 3'h0, 8'h01, 1, 8'h00, 8'h01, 6'h25, 1, CS);
    run(emod_pkg::decrement_skip_zero, 3'h0, 8'h00, 1, 8'hff, 8'h01, 6'h25, 0, CP);
    run(emod_pkg::decrement_skip_zero_acc, 3'h0, 8'h01, 0, 8'h00, 8'h00, 6'h25, 1, CS);
    run(emod_pkg::decrement_skip_zero_acc, 3'h0, 8'h05, 0, 8'h00, 8'h04, 6'h25, 0, CP);
    run(emod_pkg::increment_skip_zero, 3'h0, 8'hff, 1, 8'h00, 8'h04, 6'h25, 1, CS);
    run(emod_pkg::increment_skip_zero_acc, 3'h0, 8'hff, 0, 8'h00, 8'h00, 6'h25, 1, CS);
    run(emod_pkg::increment_skip_zero_acc, 3'h0, 8'h7f, 0, 8'h00, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::set_byte_or_bit, 3'h0, 8'h12, 1, 8'hff, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::set_bit, 3'h7, 8'h00, 1, 8'h80, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::set_bit, 3'h0, 8'h5a, 1, 8'h5b, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::skip_if_bit_nonzero, 3'h6, 8'h40, 0, 8'h00, 8'h80, 6'h25, 1, CS);
    run(emod_pkg::skip_if_bit_nonzero, 3'h6, 8'hbf, 0, 8'h00, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::skip_if_bit_zero, 3'h1, 8'hfd, 0, 8'h00, 8'h80, 6'h25, 1, CS);
    run(emod_pkg::skip_if_bit_zero, 3'h1, 8'h02, 0, 8'h00, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::skip_if_nonzero, 3'h0, 8'h10, 1, 8'h10, 8'h80, 6'h25, 1, CS);
    run(emod_pkg::skip_if_nonzero, 3'h0, 8'h00, 1, 8'h00, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::skip_if_zero, 3'h0, 8'h00, 1, 8'h00, 8'h80, 6'h25, 1, CS);
    run(emod_pkg::skip_if_zero, 3'h0, 8'h01, 1, 8'h01, 8'h80, 6'h25, 0, CP);
    run(emod_pkg::move_skip_if_zero, 3'h0, 8'h00, 0, 8'h00, 8'h00, 6'h25, 1, CS);
    run(emod_pkg::move_skip_if_zero, 3'h0, 8'h9c, 0, 8'h00, 8'h9c, 6'h25, 0, CP);
    run(emod_pkg::nibble_exchange, 3'h0, 8'h3c, 1, 8'hc3, 8'h9c, 6'h25, 0, CP);
    run(emod_pkg::nibble_exchange_acc, 3'h0, 8'h1e, 0, 8'h00, 8'he1, 6'h25, 0, CP);
    run(emod_pkg::exclusive_or_to_acc, 3'h0, 8'he1, 0, 8'h00, 8'h00, 6'h2d, 0, CP);
    run(emod_pkg::exclusive_or_to_mem, 3'h0, 8'h0f, 1, 8'h0f, 8'h00, 6'h25, 0, CP);
    setup(8'h11, 6'h25, 8'hfe, 8'h22);
    tbl(emod_pkg::table_read_page, 16'h22fe, 8'hfe);
    tbl(emod_pkg::table_read_last_page, 16'hfffe, 8'hfe);
    tbl(emod_pkg::table_read_page_preinc, 16'h22ff, 8'hff);
    // Low pointer wraps to zero; the high byte must not follow it
    tbl(emod_pkg::table_read_last_preinc, 16'hff00, 8'h00);
    chk("tptr_high", 16'h0022, 16'(o_table_pointer_high));
    // Enable low must keep a request from being taken and freeze registers
    @(negedge i_clk);
    i_ce = 1'b0;
    i_start = 1'b1;
    i_req = '{emod_pkg::rotate_right_to_acc, 3'h0, 8'h01};
    repeat (3) @(negedge i_clk);
    chk("frozen_busy", 16'h0000, 16'(o_busy));
    chk("frozen_done", 16'h0000, 16'(o_done));
    chk("frozen_acc", 16'h0011, 16'(o_acc));
    i_start = 1'b0;
    i_ce = 1'b1;
    $display("test clock_enable done");
    // Expected subtract results worked out independently of the design
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 3; i++) begin
        brw = (j < 2);
        b = brw & ~sf[i][5];
        d = {1'b0, sa[i]} - {1'b0, sm[i]} - 9'(b);
        h = {1'b0, sa[i][3:0]} - {1'b0, sm[i][3:0]} - 5'(b);
        ov = (sa[i][7] ^ sm[i][7]) & (d[7] ^ sa[i][7]);
        z = (d[7:0] == 8'h00);
        e = {d[7:0], ~d[8], ~h[4], z, ov, d[7] ^ ov, brw ? z & sf[i][0] : z};
        setup(sa[i], sf[i], 8'h00, 8'h00);
        run(sops[j], 3'h0, sm[i], j[0], e[13:6], j[0] ? sa[i] : e[13:6], e[5:0], 0, CP);
      end
    end
    stop_test();
  end
endmodule : emod_datapath_tb
